// [design/ptb_pkg.sv]
// Package for the PWM time base control block
// Notes on behaviour
// - The modulation module runs only while module_on (bit 15) is 1.
// - With halt_in_idle (bit 13) set, the time base stops in CPU Idle.
// - Hardware holds special_event_pending (bit 12) while it is pending.
// - The special event interrupt needs special_event_irq_en (bit 11).
// - immediate_period_load (bit 10) loads a period at once, else at wrap or while module_on is 0.
// - sync_active_low (bit 9) makes sync input and output active low.
// - The sync output is driven only while sync_out_en (bit 8) is 1.
// - ext_sync_en (bit 7) lets the external sync input restart the count.
// - Bit 14 of the control register reads as zero.
package ptb_pkg;
  localparam logic [11:0] PTB_ADDR_CTRL   = 12'h000;
  localparam logic [11:0] PTB_ADDR_PERIOD = 12'h004;
  localparam logic [11:0] PTB_ADDR_SEVT   = 12'h008;
  localparam logic [11:0] PTB_ADDR_COUNT  = 12'h00C;
  localparam logic [11:0] PTB_ADDR_STAT   = 12'h010;
  localparam logic [11:0] PTB_ADDR_MASK   = 12'h014;
  localparam int BIT_ON     = 15;
  localparam int BIT_IDLE   = 13;
  localparam int BIT_SEST   = 12;
  localparam int BIT_SEIRQ  = 11;
  localparam int BIT_IMM    = 10;
  localparam int BIT_POL    = 9;
  localparam int BIT_SOEN   = 8;
  localparam int BIT_SYEN   = 7;
  localparam logic [15:0] CTRL_RESET   = 16'h0000;
  localparam logic [15:0] CTRL_WR_MASK = 16'hAFFF;
  localparam logic [15:0] PERIOD_RESET = 16'hFFFF;
  localparam logic [15:0] SEVT_RESET   = 16'h0000;
  localparam int STAT_W = 3;
  localparam int EV_SEVT = 0;
  localparam int EV_WRAP = 1;
  localparam int EV_SYNC = 2;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [15:0] CNT_ONE  = 16'h0001;
  localparam logic [3:0]  PS_ZERO  = 4'h0;
  localparam logic [3:0]  PS_ONE   = 4'h1;
endpackage

// [design/ptb_sync2.sv]
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/10ps
module ptb_sync2
  import ptb_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic srst,
  input  wire logic din,
  output logic      dout
);
  logic stage1Reg;
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      stage1Reg <= 1'b0;
      dout      <= 1'b0;
    end
    else
    begin
      stage1Reg <= din;
      dout      <= stage1Reg;
    end
  end
endmodule

// [design/ptb_time_base.sv]
// PWM primary time base with control register and APB slave
`timescale 1ns/10ps
module ptb_time_base
  import ptb_pkg::*;
#(
  parameter int CW = 16
)
(
  input  wire logic        sys_clk,
  input  wire logic        srst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        cpuIdle,
  input  wire logic        sync_in_pin,
  output logic             sync_out_pin,
  output logic             syncOutEn_n,
  output logic             pwmRun,
  output logic [CW-1:0]    tbCount,
  output logic             irq
);
  logic [15:0]   ctrlReg;
  logic [CW-1:0] periodReg;
  logic [CW-1:0] activePeriodReg;
  logic [CW-1:0] sevtCmpReg;
  logic [CW-1:0] countReg;
  logic [3:0]    psCountReg;
  logic          pendReg;
  logic [STAT_W-1:0] statReg;
  logic [STAT_W-1:0] maskReg;
  logic          syncPinS;
  logic          syncPrevReg;
  logic          syncEvent;
  logic          running;
  logic          atEnd;
  logic          sevtHit;
  logic          psDone;
  logic          wrEn;
  logic          rdEn;
  logic          addrOk;
  logic [31:0]   rdData;
  logic [STAT_W-1:0] evt;

  ptb_sync2 uSync
  (
    .sys_clk (sys_clk),
    .srst    (srst),
    .din     (sync_in_pin),
    .dout    (syncPinS)
  );

  assign wrEn = psel && penable && pwrite && pready;
  assign rdEn = psel && penable && !pwrite && pready;

  // Polarity folded in after the synchroniser
  assign syncEvent = ctrlReg[BIT_SYEN]
    && ((syncPinS ^ ctrlReg[BIT_POL])
    && !(syncPrevReg ^ ctrlReg[BIT_POL]));

  assign running = ctrlReg[BIT_ON]
    && !(ctrlReg[BIT_IDLE] && cpuIdle);
  assign atEnd   = countReg >= activePeriodReg;
  assign sevtHit = running && (countReg == sevtCmpReg);
  assign psDone  = sevtHit && (psCountReg >= ctrlReg[3:0]);

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      syncPrevReg <= 1'b0;
    else
      syncPrevReg <= syncPinS;
  end

  // Control register; bit 14 and bit 12 not writable
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      ctrlReg <= CTRL_RESET;
    else if (wrEn && paddr == PTB_ADDR_CTRL)
      ctrlReg <= pwdata[15:0] & CTRL_WR_MASK;
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      periodReg  <= PERIOD_RESET[CW-1:0];
      sevtCmpReg <= SEVT_RESET[CW-1:0];
    end
    else if (wrEn)
    begin
      if (paddr == PTB_ADDR_PERIOD)
        periodReg <= pwdata[CW-1:0];
      if (paddr == PTB_ADDR_SEVT)
        sevtCmpReg <= pwdata[CW-1:0];
    end
  end

  // Active period: at once, or at wrap and while the module is off
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      activePeriodReg <= PERIOD_RESET[CW-1:0];
    else if (ctrlReg[BIT_IMM])
      activePeriodReg <= periodReg;
    else if (!ctrlReg[BIT_ON] || (running && atEnd))
      activePeriodReg <= periodReg;
  end

  // Counter held in place while halted so resume is seamless
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      countReg <= CNT_ZERO[CW-1:0];
    else if (!ctrlReg[BIT_ON])
      countReg <= CNT_ZERO[CW-1:0];
    else if (running && (syncEvent || atEnd))
      countReg <= CNT_ZERO[CW-1:0];
    else if (running)
      countReg <= countReg + CNT_ONE[CW-1:0];
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      psCountReg <= PS_ZERO;
    else if (!ctrlReg[BIT_ON] || psDone)
      psCountReg <= PS_ZERO;
    else if (sevtHit)
      psCountReg <= psCountReg + PS_ONE;
  end

  // Pending stays while enabled until a one is written to status bit 0; hardware clears when disabled
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      pendReg <= 1'b0;
    else if (!ctrlReg[BIT_SEIRQ])
      pendReg <= 1'b0;
    else if (psDone)
      pendReg <= 1'b1;
    else if (wrEn && paddr == PTB_ADDR_STAT && pwdata[EV_SEVT])
      pendReg <= 1'b0;
  end

  assign evt[EV_SEVT] = psDone && ctrlReg[BIT_SEIRQ];
  assign evt[EV_WRAP] = running && atEnd;
  assign evt[EV_SYNC] = running && syncEvent;

  // Set wins over write-one-to-clear
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      statReg <= '0;
    else if (wrEn && paddr == PTB_ADDR_STAT)
      statReg <= (statReg & ~pwdata[STAT_W-1:0]) | evt;
    else
      statReg <= statReg | evt;
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      maskReg <= '0;
    else if (wrEn && paddr == PTB_ADDR_MASK)
      maskReg <= pwdata[STAT_W-1:0];
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      irq <= 1'b0;
    else
      irq <= |(statReg & maskReg);
  end

  // Sync output pulse at wrap, gated by enable
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      sync_out_pin <= 1'b0;
      syncOutEn_n  <= 1'b1;
    end
    else
    begin
      syncOutEn_n  <= !ctrlReg[BIT_SOEN];
      sync_out_pin <= ctrlReg[BIT_POL]
        ^ (ctrlReg[BIT_SOEN] && running && atEnd);
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      pwmRun  <= 1'b0;
      tbCount <= CNT_ZERO[CW-1:0];
    end
    else
    begin
      pwmRun  <= ctrlReg[BIT_ON];
      tbCount <= countReg;
    end
  end

  assign addrOk = paddr == PTB_ADDR_CTRL || paddr == PTB_ADDR_PERIOD
    || paddr == PTB_ADDR_SEVT || paddr == PTB_ADDR_COUNT
    || paddr == PTB_ADDR_STAT || paddr == PTB_ADDR_MASK;

  always_comb
  begin
    rdData = '0;
    unique case (paddr)
      PTB_ADDR_CTRL:
      begin
        rdData[15:0]     = ctrlReg;
        rdData[BIT_SEST] = pendReg;
      end
      PTB_ADDR_PERIOD: rdData[CW-1:0] = periodReg;
      PTB_ADDR_SEVT:   rdData[CW-1:0] = sevtCmpReg;
      PTB_ADDR_COUNT:  rdData[CW-1:0] = countReg;
      PTB_ADDR_STAT:   rdData[STAT_W-1:0] = statReg;
      PTB_ADDR_MASK:   rdData[STAT_W-1:0] = maskReg;
      default:         rdData = '0;
    endcase
  end

  // One wait state: pready rises in the second access cycle
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end
    else
    begin
      pready  <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !addrOk;
      prdata  <= (psel && penable && !pwrite && !pready) ? rdData : '0;
    end
  end

  a_off_holds_count: assert property (
    @(posedge sys_clk) disable iff (srst)
    !ctrlReg[BIT_ON] |=> countReg == '0)
    else $error("count not held at zero while off");

  a_idle_halts_count: assert property (
    @(posedge sys_clk) disable iff (srst)
    (ctrlReg[BIT_ON] && ctrlReg[BIT_IDLE] && cpuIdle) |=> $stable(countReg))
    else $error("count moved in idle halt");

  a_pend_set: assert property (
    @(posedge sys_clk) disable iff (srst)
    (psDone && ctrlReg[BIT_SEIRQ]) |=> pendReg)
    else $error("pending not set on event");

  a_pend_disabled: assert property (
    @(posedge sys_clk) disable iff (srst)
    !ctrlReg[BIT_SEIRQ] |=> !pendReg)
    else $error("pending while interrupt disabled");

  a_imm_period: assert property (
    @(posedge sys_clk) disable iff (srst)
    ctrlReg[BIT_IMM] |=> activePeriodReg == $past(periodReg))
    else $error("immediate period not loaded");

  a_sync_out_off: assert property (
    @(posedge sys_clk) disable iff (srst)
    !ctrlReg[BIT_SOEN] |=> syncOutEn_n
      && sync_out_pin == $past(ctrlReg[BIT_POL]))
    else $error("sync output active while disabled");

  a_sync_restart: assert property (
    @(posedge sys_clk) disable iff (srst)
    (running && syncEvent) |=> countReg == '0)
    else $error("external sync did not restart count");

  a_bit14_zero: assert property (
    @(posedge sys_clk) disable iff (srst)
    (pready && !pwrite && paddr == PTB_ADDR_CTRL) |-> !prdata[14])
    else $error("bit 14 read as one");

  a_oe_follows: assert property (
    @(posedge sys_clk) disable iff (srst)
    ctrlReg[BIT_SOEN] |=> !syncOutEn_n)
    else $error("sync output not enabled");

  a_run_mirror: assert property (
    @(posedge sys_clk) disable iff (srst)
    1'b1 |=> pwmRun == $past(ctrlReg[BIT_ON]))
    else $error("run output does not follow enable");

  a_idle_runs_on: assert property (
    @(posedge sys_clk) disable iff (srst)
    (ctrlReg[BIT_ON] && !ctrlReg[BIT_IDLE] && !syncEvent && !atEnd)
      |=> countReg == $past(countReg) + CNT_ONE[CW-1:0])
    else $error("count stopped although idle halt is off");

  a_pend_clear: assert property (
    @(posedge sys_clk) disable iff (srst)
    (!psDone && wrEn && paddr == PTB_ADDR_STAT && pwdata[EV_SEVT])
      |=> !pendReg)
    else $error("pending not cleared by write");

  a_pend_hold: assert property (
    @(posedge sys_clk) disable iff (srst)
    (pendReg && ctrlReg[BIT_SEIRQ] && !(wrEn && paddr == PTB_ADDR_STAT))
      |=> pendReg)
    else $error("pending dropped on its own");

  a_irq_level: assert property (
    @(posedge sys_clk) disable iff (srst)
    (|(statReg & maskReg)) |=> irq)
    else $error("interrupt not raised for unmasked status");

  a_sevt_gated: assert property (
    @(posedge sys_clk) disable iff (srst)
    !ctrlReg[BIT_SEIRQ] |-> !evt[EV_SEVT])
    else $error("special event status while disabled");

  a_wait_load: assert property (
    @(posedge sys_clk) disable iff (srst)
    (!ctrlReg[BIT_IMM] && ctrlReg[BIT_ON] && !(running && atEnd))
      |=> activePeriodReg == $past(activePeriodReg))
    else $error("period loaded before the cycle boundary");

  a_off_no_pulse: assert property (
    @(posedge sys_clk) disable iff (srst)
    !ctrlReg[BIT_ON] |=> sync_out_pin == $past(ctrlReg[BIT_POL]))
    else $error("sync pulse while module is off");

  a_sync_gated: assert property (
    @(posedge sys_clk) disable iff (srst)
    !ctrlReg[BIT_SYEN] |-> !syncEvent)
    else $error("sync event while external sync is off");

  a_fields_stored: assert property (
    @(posedge sys_clk) disable iff (srst)
    (wrEn && paddr == PTB_ADDR_CTRL) |=> ctrlReg[6:0] == $past(pwdata[6:0]))
    else $error("source or postscale field not stored");

  a_ready_pulse: assert property (
    @(posedge sys_clk) disable iff (srst)
    pready |=> !pready)
    else $error("ready held longer than one cycle");
endmodule

// [dv/ptb_sync_partner.sv]
// External sync source model driving the sync input pin
`timescale 1ns/10ps
module ptb_sync_partner (
  input  wire logic sys_clk,
  input  wire logic activeLow,
  input  wire logic fire,
  output logic      syncPin
);
  logic [2:0] holdCnt;
  initial holdCnt = 3'h0;
  // Pulse held 4 cycles so the 2-flop synchroniser cannot miss it
  always_ff @(posedge sys_clk)
  begin
    if (fire)
      holdCnt <= 3'h4;
    else if (holdCnt != 3'h0)
      holdCnt <= holdCnt - 3'h1;
  end
  // Idle at the inactive level of the chosen polarity
  assign syncPin = (holdCnt != 3'h0) ^ activeLow;
endmodule

// [dv/pwm_time_base_control_bench.sv]
// Self-checking bench for the PWM time base control block
`timescale 1ns/10ps
module pwm_time_base_control_bench;
  import ptb_pkg::*;
  logic        sys_clk = 0, srst = 1, psel = 0, penable = 0;
  logic        pwrite = 0, cpuIdle = 0, fire = 0, syncIn;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, q, q2;
  logic        pready, pslverr, syncOut, syncOutEn_n, pwmRun, irq;
  logic        lastErr, syncLow = 0;
  logic [15:0] tbCount;
  int          err_count = 0, num_checks = 0;

  always #25 sys_clk = ~sys_clk;

  ptb_time_base dut_u (.sys_clk(sys_clk), .srst(srst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cpuIdle(cpuIdle), .sync_in_pin(syncIn), .sync_out_pin(syncOut),
    .syncOutEn_n(syncOutEn_n), .pwmRun(pwmRun), .tbCount(tbCount),
    .irq(irq));

  ptb_sync_partner partner_u (.sys_clk(sys_clk), .activeLow(syncLow),
    .fire(fire), .syncPin(syncIn));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (n >= 50)
      chk(32'h0000_0001, 32'h0000_0000);
    q       = prdata;
    lastErr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [11:0] a);
    apb(1'b0, a, 32'h0000_0000);
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic waitPin(input logic lv);
    int n;
    n = 0;
    while (syncOut !== lv && n < 40)
    begin
      @(posedge sys_clk);
      n++;
    end
    chk({31'h0, syncOut}, {31'h0, lv});
  endtask

  task automatic done(input string name);
    $display("test %s finished", name);
  endtask

  task automatic print_verdict;
    $display("checks=%0d mismatches=%0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial
  begin
    tick(20000);
    err_count++;
    print_verdict;
  end

  initial
  begin
    tick(6);
    srst <= 1'b0;
    @(posedge sys_clk);
    rd(PTB_ADDR_CTRL);   chk(q, {16'h0, CTRL_RESET});
    rd(PTB_ADDR_PERIOD); chk(q, {16'h0, PERIOD_RESET});
    rd(PTB_ADDR_SEVT);   chk(q, {16'h0, SEVT_RESET});
    rd(12'h018);         chk({31'h0, lastErr}, 32'h0000_0001);
    wr(PTB_ADDR_CTRL, 32'h0000_67FF);
    rd(PTB_ADDR_CTRL);   chk(q, 32'h0000_27FF);
    done("register");
    wr(PTB_ADDR_CTRL, 32'h0000_0000);
    wr(PTB_ADDR_PERIOD, 32'h0000_0009);
    rd(PTB_ADDR_COUNT);  chk(q, 32'h0000_0000);
    wr(PTB_ADDR_CTRL, 32'h0000_A000);
    tick(1);
    chk({31'h0, pwmRun}, 32'h0000_0001);
    rd(PTB_ADDR_COUNT);  q2 = q;
    rd(PTB_ADDR_COUNT);  chk({31'h0, q != q2}, 32'h0000_0001);
    cpuIdle <= 1'b1;
    tick(3);
    rd(PTB_ADDR_COUNT);  q2 = q;
    tick(5);
    rd(PTB_ADDR_COUNT);  chk(q, q2);
    chk({16'h0, tbCount}, q2);
    cpuIdle <= 1'b0;
    done("run_idle");
    wr(PTB_ADDR_CTRL, 32'h0000_0000);
    wr(PTB_ADDR_SEVT, 32'h0000_0003);
    wr(PTB_ADDR_MASK, 32'h0000_0001);
    wr(PTB_ADDR_STAT, 32'h0000_0007);
    wr(PTB_ADDR_CTRL, 32'h0000_8800);
    tick(30);
    chk({31'h0, irq}, 32'h0000_0001);
    rd(PTB_ADDR_CTRL);   chk(q, 32'h0000_9800);
    wr(PTB_ADDR_CTRL, 32'h0000_8000);
    rd(PTB_ADDR_CTRL);   chk(q, 32'h0000_8000);
    wr(PTB_ADDR_MASK, 32'h0000_0000);
    tick(2);
    chk({31'h0, irq}, 32'h0000_0000);
    wr(PTB_ADDR_CTRL, 32'h0000_0000);
    wr(PTB_ADDR_STAT, 32'h0000_0007);
    rd(PTB_ADDR_STAT);   chk(q, 32'h0000_0000);
    done("special_event");
    wr(PTB_ADDR_CTRL, 32'h0000_0100);
    wr(PTB_ADDR_CTRL, 32'h0000_8100);
    chk({31'h0, syncOutEn_n}, 32'h0000_0000);
    waitPin(1'b1);
    wr(PTB_ADDR_CTRL, 32'h0000_0300);
    tick(1);
    chk({31'h0, syncOut}, 32'h0000_0001);
    wr(PTB_ADDR_CTRL, 32'h0000_8300);
    waitPin(1'b0);
    wr(PTB_ADDR_CTRL, 32'h0000_0000);
    tick(1);
    chk({31'h0, syncOutEn_n}, 32'h0000_0001);
    done("sync_out");
    wr(PTB_ADDR_PERIOD, 32'h0000_FFFF);
    wr(PTB_ADDR_CTRL, 32'h0000_8080);
    tick(40);
    fire <= 1'b1;
    @(posedge sys_clk);
    fire <= 1'b0;
    tick(8);
    rd(PTB_ADDR_COUNT);  chk({31'h0, q < 32'd16}, 32'h0000_0001);
    rd(PTB_ADDR_STAT);   chk(q & 32'h4, 32'h0000_0004);
    done("ext_sync");
    wr(PTB_ADDR_CTRL, 32'h0000_0000);
    syncLow <= 1'b1;
    wr(PTB_ADDR_STAT, 32'h0000_0007);
    wr(PTB_ADDR_CTRL, 32'h0000_8280);
    tick(40);
    fire <= 1'b1;
    @(posedge sys_clk);
    fire <= 1'b0;
    tick(8);
    rd(PTB_ADDR_COUNT);  chk({31'h0, q < 32'h0000_0010}, 32'h0000_0001);
    rd(PTB_ADDR_STAT);   chk(q & 32'h4, 32'h0000_0004);
    done("ext_sync_low");
    wr(PTB_ADDR_CTRL, 32'h0000_0000);
    wr(PTB_ADDR_CTRL, 32'h0000_8000);
    tick(30);
    wr(PTB_ADDR_PERIOD, 32'h0000_0005);
    rd(PTB_ADDR_COUNT);  chk({31'h0, q > 32'd5}, 32'h0000_0001);
    wr(PTB_ADDR_CTRL, 32'h0000_0000);
    wr(PTB_ADDR_CTRL, 32'h0000_0400);
    wr(PTB_ADDR_PERIOD, 32'h0000_FFFF);
    wr(PTB_ADDR_CTRL, 32'h0000_8400);
    tick(30);
    wr(PTB_ADDR_PERIOD, 32'h0000_0005);
    tick(3);
    rd(PTB_ADDR_COUNT);  chk({31'h0, q <= 32'd5}, 32'h0000_0001);
    done("period_load");
    print_verdict;
  end
endmodule
